// file: common/ppmc_consts.svh
// Purpose: shared numbers of the port power and mode control block
// Assumes: one 40 MHz crystal clock
// Notes:   times are in ns, cycle counts derive from them
`ifndef PPMC_CONSTS_SVH
`define PPMC_CONSTS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define PPMC_CLK_NS       25
`define PPMC_TICK_NS      1000000
`define PPMC_TICK_CYC     (`PPMC_TICK_NS / `PPMC_CLK_NS)
`define PPMC_MASK_BASE    8'h08
`define PPMC_PULSE_BASE   8'h10

// ----------------------------------------
// indicator select codes
// ----------------------------------------
`define PPMC_LED_RSVD_A   4'hb
`define PPMC_LED_PDF      4'hc
`define PPMC_LED_RSVD_B   4'hd
`define PPMC_LED_OFF      4'he
`define PPMC_LED_ON       4'hf

// ----------------------------------------
// strap and synchroniser layout
// ----------------------------------------
`define PPMC_STRAP_SPD    4'h4
`define PPMC_STRAP_WAIT   3'h5
`define PPMC_SYNC_W       10
`define PPMC_SYNC_SUSP    0
`define PPMC_SYNC_EN_LO   1
`define PPMC_SYNC_EN_HI   4
`define PPMC_SYNC_ST_LO   5
`define PPMC_SYNC_ST_HI   9

// ----------------------------------------
// management address spaces and pair masks
// ----------------------------------------
`define PPMC_MMD_PMA      5'h01
`define PPMC_PAIR_ALL     4'hf
`define PPMC_PAIR_AB      4'h3

`endif

// file: common/ppmc_pkg.sv
// Purpose: types of the port power and mode control block
// Assumes: nothing
// Notes:   numbers live in ppmc_consts.svh
package ppmc_pkg;

	// ----------------------------------------
	// energy-detect power-down states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ED_OFF,   // normal operation
		ED_MASK,  // energy gone, waiting out the mask time
		ED_IDLE   // powered down, only tx pulses and detect
	} ppmc_ed_state_t;

endpackage

// file: common/ppmc_sync_if.sv
// Purpose: carries raw pins into the synchroniser and clean levels back
// Assumes: clk is the crystal clock
// Notes:   width fixed by PPMC_SYNC_W
`timescale 1ns/1ps
`include "ppmc_consts.svh"
interface ppmc_sync_if (
	input wire logic clk,
	input wire logic rst_b
);
	logic [`PPMC_SYNC_W-1:0] raw;    // asynchronous pin levels
	logic [`PPMC_SYNC_W-1:0] clean;  // levels after agreement

	modport sync (input clk, input rst_b, input raw, output clean);
	modport user (input clean, output raw);
endinterface

// file: core/ppmc_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are static for at least two clocks per change
// Notes:   a change is accepted once stages two and three agree
`timescale 1ns/1ps
`include "ppmc_consts.svh"
module ppmc_sync (
	ppmc_sync_if.sync sif
);
	logic [`PPMC_SYNC_W-1:0] s1;        // first stage, feeds s2 only
	logic [`PPMC_SYNC_W-1:0] s2;        // second stage
	logic [`PPMC_SYNC_W-1:0] s3;        // third stage
	logic [`PPMC_SYNC_W-1:0] q;         // accepted level
	logic [`PPMC_SYNC_W-1:0] next_q;    // next accepted level

	// ----------------------------------------
	// agreement filter, one bit at a time
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `PPMC_SYNC_W; g++) begin : g_bit
			// take the new level only when two stages agree
			always_comb begin
				next_q[g] = (s2[g] == s3[g]) ? s2[g] : q[g];
			end
		end
	endgenerate

	// register all stages
	always_ff @(posedge sif.clk) begin
		if (!sif.rst_b) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q  <= '0;
		end else begin
			s1 <= sif.raw;
			s2 <= s1;
			s3 <= s2;
			q  <= next_q;
		end
	end

	assign sif.clean = q;
endmodule

// file: core/ppmc_top.sv
// Purpose: per-port suspend, energy-detect and software power-down control
// Assumes: i_mclk is the 40 MHz crystal clock, always running
// Notes:   control bits come from the owning register file as plain ports
`timescale 1ns/1ps
`include "ppmc_consts.svh"
module ppmc_top
	import ppmc_pkg::*;
#(
	parameter int unsigned TICK_CYC = `PPMC_TICK_CYC
) (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_b,
	input  wire logic       i_suspend_pin,
	input  wire logic [4:0] i_mode_strap,
	input  wire logic [3:0] i_energy_det,
	input  wire logic       i_edpd_en,
	input  wire logic [1:0] i_edpd_mask_timer,
	input  wire logic [1:0] i_edpd_pulse_timer,
	input  wire logic       i_edpd_rand_dis,
	input  wire logic       i_idle_pll_off,
	input  wire logic       i_force_1000,
	input  wire logic       i_cable_diag,
	input  wire logic [1:0] i_pair_sel,
	input  wire logic       i_energy_chg_clr,
	input  wire logic       i_pd_wr,
	input  wire logic       i_pd_wdata,
	input  wire logic       i_spd_pll_off,
	input  wire logic       i_spd_cg_override,
	input  wire logic       i_isolate_bit,
	input  wire logic [3:0] i_led_sel,
	input  wire logic       i_led_lo_state,
	input  wire logic       i_pdf,
	input  wire logic       i_phy_link_up,
	input  wire logic       i_phy_event,
	input  wire logic       i_phy_irq,
	input  wire logic       i_mgmt_req,
	input  wire logic       i_mgmt_mmd,
	input  wire logic [4:0] i_mgmt_devad,
	output logic            o_port_indicator_output,
	output logic            o_link_up,
	output logic            o_event,
	output logic            o_irq,
	output logic            o_phy_enable,
	output logic            o_data_en,
	output logic            o_rec_clk_en,
	output logic            o_clk_fast_en,
	output logic            o_txrx_clk_en,
	output logic            o_pll_en,
	output logic            o_edpd_active,
	output logic            o_link_pulse,
	output logic [3:0]      o_pair_mon,
	output logic            o_energy_status,
	output logic            o_energy_chg,
	output logic            o_spd,
	output logic            o_dev_reset,
	output logic            o_mgmt_grant,
	output logic            o_mgmt_refuse
);
	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	// indicator level for one select code
	function automatic logic led_decode(input logic [3:0] sel, input logic lo, input logic pdf);
		logic r;
		r = lo;
		unique case (sel)
			`PPMC_LED_PDF:    r = pdf;
			`PPMC_LED_OFF:    r = 1'b0;
			`PPMC_LED_ON:     r = 1'b1;
			`PPMC_LED_RSVD_A: r = 1'b0;
			`PPMC_LED_RSVD_B: r = 1'b0;
			default:          r = lo;
		endcase
		return r;
	endfunction

	// interval in ticks from a base and a two-bit field
	function automatic logic [7:0] interval(input logic [7:0] base, input logic [1:0] sel);
		return 8'(base << sel);
	endfunction

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	ppmc_sync_if u_sif (
		.clk   (i_mclk),
		.rst_b (i_rst_b)
	);
	assign u_sif.raw = {i_mode_strap, i_energy_det, i_suspend_pin};

	ppmc_sync u_sync (
		.sif (u_sif.sync)
	);

	logic       suspend;      // filtered suspend level
	logic [3:0] energy;       // filtered per-pair energy
	logic [4:0] strap;        // filtered mode strap
	logic [3:0] pair_mask;    // pairs being watched
	logic       energy_any;   // energy on any watched pair
	assign suspend = u_sif.clean[`PPMC_SYNC_SUSP];
	assign energy  = u_sif.clean[`PPMC_SYNC_EN_HI:`PPMC_SYNC_EN_LO];
	assign strap   = u_sif.clean[`PPMC_SYNC_ST_HI:`PPMC_SYNC_ST_LO];

	// pick the monitored pairs
	always_comb begin
		pair_mask = `PPMC_PAIR_AB;
		if (i_force_1000 && i_cable_diag) begin
			pair_mask = 4'(4'h1 << i_pair_sel);
		end else if (i_force_1000) begin
			pair_mask = `PPMC_PAIR_ALL;
		end
	end
	assign energy_any = |(energy & pair_mask);

	// ----------------------------------------
	// energy-detect power-down
	// ----------------------------------------
	ppmc_ed_state_t ed_state;        // power-down state
	ppmc_ed_state_t next_ed_state;
	logic [15:0]    tick_cnt;        // divider toward the slow tick
	logic [15:0]    next_tick_cnt;
	logic           tick;            // one-cycle slow enable
	logic           next_tick;
	logic [7:0]     mask_cnt;        // ticks left before power-down
	logic [7:0]     next_mask_cnt;
	logic [7:0]     pulse_cnt;       // ticks left to next link pulse
	logic [7:0]     next_pulse_cnt;
	logic [3:0]     lfsr;            // jitter source
	logic [3:0]     next_lfsr;
	logic           link_pulse;      // request one link pulse
	logic           next_link_pulse;
	logic [7:0]     pulse_reload;    // next pulse spacing

	// pulse spacing with optional random spread
	always_comb begin
		pulse_reload = interval(`PPMC_PULSE_BASE, i_edpd_pulse_timer);
		if (!i_edpd_rand_dis) begin
			pulse_reload = pulse_reload + {6'h00, lfsr[1:0]};
		end
	end

	// next state of the power-down sequencer
	always_comb begin
		next_tick_cnt   = tick_cnt + 16'h0001;
		next_tick       = 1'b0;
		next_lfsr       = {lfsr[2:0], lfsr[3] ^ lfsr[2]};
		next_ed_state   = ed_state;
		next_mask_cnt   = mask_cnt;
		next_pulse_cnt  = pulse_cnt;
		next_link_pulse = 1'b0;
		if (tick_cnt == 16'(TICK_CYC - 1)) begin
			next_tick_cnt = 16'h0000;
			next_tick     = 1'b1;
		end
		unique case (ed_state)
			ED_OFF: begin
				// only an enabled port may power down
				if (i_edpd_en && !energy_any) begin
					next_ed_state = ED_MASK;
					next_mask_cnt = interval(`PPMC_MASK_BASE, i_edpd_mask_timer);
				end
			end
			ED_MASK: begin
				if (!i_edpd_en || energy_any) begin
					next_ed_state = ED_OFF;
				end else if (tick) begin
					if (mask_cnt == 8'h00) begin
						next_ed_state  = ED_IDLE;
						next_pulse_cnt = pulse_reload;
					end else begin
						next_mask_cnt = mask_cnt - 8'h01;
					end
				end
			end
			ED_IDLE: begin
				// wake on energy or when software disables
				if (!i_edpd_en || energy_any) begin
					next_ed_state = ED_OFF;
				end else if (tick) begin
					if (pulse_cnt == 8'h00) begin
						next_link_pulse = 1'b1;
						next_pulse_cnt  = pulse_reload;
					end else begin
						next_pulse_cnt = pulse_cnt - 8'h01;
					end
				end
			end
		endcase
	end

	// register the power-down sequencer
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			ed_state   <= ED_OFF;
			tick_cnt   <= 16'h0000;
			tick       <= 1'b0;
			mask_cnt   <= 8'h00;
			pulse_cnt  <= 8'h00;
			lfsr       <= 4'h1;
			link_pulse <= 1'b0;
		end else begin
			ed_state   <= next_ed_state;
			tick_cnt   <= next_tick_cnt;
			tick       <= next_tick;
			mask_cnt   <= next_mask_cnt;
			pulse_cnt  <= next_pulse_cnt;
			lfsr       <= next_lfsr;
			link_pulse <= next_link_pulse;
		end
	end

	// ----------------------------------------
	// software power-down, PLL and device reset
	// ----------------------------------------
	logic       ed_idle;         // port in energy power-down
	logic       spd;             // software power-down state
	logic       next_spd;
	logic [2:0] strap_cnt;       // wait for the strap to settle
	logic [2:0] next_strap_cnt;
	logic       pll_off;         // PLL held off last cycle
	logic       pll_off_now;     // PLL held off this cycle
	logic       dev_reset;       // device reset request
	logic       next_dev_reset;
	assign ed_idle = (ed_state == ED_IDLE);

	// next power-down and reset state
	always_comb begin
		pll_off_now    = (ed_idle && i_idle_pll_off) || (spd && i_spd_pll_off);
		next_dev_reset = pll_off && !pll_off_now;
		next_spd       = spd;
		next_strap_cnt = strap_cnt;
		if (strap_cnt != `PPMC_STRAP_WAIT) begin
			next_strap_cnt = strap_cnt + 3'h1;
			if (strap_cnt == `PPMC_STRAP_WAIT - 3'h1) begin
				next_spd = (strap[4:1] == `PPMC_STRAP_SPD);
			end
		end else if (dev_reset) begin
			// restart from the strap defaults
			next_strap_cnt = 3'h0;
		end else if (i_pd_wr) begin
			next_spd = i_pd_wdata;
		end
	end

	// register power-down and reset state
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			spd       <= 1'b0;
			strap_cnt <= 3'h0;
			pll_off   <= 1'b0;
			dev_reset <= 1'b0;
		end else begin
			spd       <= next_spd;
			strap_cnt <= next_strap_cnt;
			pll_off   <= pll_off_now;
			dev_reset <= next_dev_reset;
		end
	end

	// ----------------------------------------
	// energy change latch
	// ----------------------------------------
	logic energy_prev;        // energy level last cycle
	logic energy_chg;         // sticky change flag
	logic next_energy_chg;

	// set beats clear in the same cycle
	always_comb begin
		next_energy_chg = energy_chg;
		if (i_energy_chg_clr) begin
			next_energy_chg = 1'b0;
		end
		// changes seen while the synchroniser refills after a reset are not real
		if ((energy_any != energy_prev) && !suspend && strap_cnt == `PPMC_STRAP_WAIT) begin
			next_energy_chg = 1'b1;
		end
	end

	// register the change latch
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			energy_prev <= 1'b0;
			energy_chg  <= 1'b0;
		end else begin
			energy_prev <= energy_any;
			energy_chg  <= next_energy_chg;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	logic       fast_on;          // fast clocks allowed
	logic       quiet;            // no traffic of any kind
	logic       mmd_ok;           // management access allowed
	logic       n_ind;
	logic       n_link;
	logic       n_evt;
	logic       n_irq;
	logic       n_data;
	logic       n_rec;
	logic       n_txrx;

	// derive the gated output levels
	always_comb begin
		fast_on = !spd || i_spd_cg_override;
		quiet   = suspend || spd || ed_state != ED_OFF;
		n_ind   = led_decode(i_led_sel, i_led_lo_state, i_pdf)
		          && !suspend && !spd && !i_isolate_bit;
		n_link  = i_phy_link_up && !suspend && ed_state == ED_OFF;
		n_evt   = i_phy_event && !suspend;
		n_irq   = i_phy_irq && !suspend;
		n_data  = !quiet && !i_isolate_bit;
		n_rec   = !quiet;
		n_txrx  = fast_on && !i_isolate_bit;
		mmd_ok  = 1'b1;
		if (spd && i_mgmt_mmd) begin
			if (i_mgmt_devad == `PPMC_MMD_PMA) begin
				mmd_ok = 1'b0;
			end else begin
				mmd_ok = i_spd_cg_override;
			end
		end
	end

	// register every output
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_port_indicator_output <= 1'b0;
			o_link_up       <= 1'b0;
			o_event         <= 1'b0;
			o_irq           <= 1'b0;
			o_phy_enable    <= 1'b0;
			o_data_en       <= 1'b0;
			o_rec_clk_en    <= 1'b0;
			o_clk_fast_en   <= 1'b0;
			o_txrx_clk_en   <= 1'b0;
			o_pll_en        <= 1'b1;
			o_edpd_active   <= 1'b0;
			o_link_pulse    <= 1'b0;
			o_pair_mon      <= 4'h0;
			o_energy_status <= 1'b0;
			o_energy_chg    <= 1'b0;
			o_spd           <= 1'b0;
			o_dev_reset     <= 1'b0;
			o_mgmt_grant    <= 1'b0;
			o_mgmt_refuse   <= 1'b0;
		end else begin
			o_port_indicator_output <= n_ind;
			o_link_up       <= n_link;
			o_event         <= n_evt;
			o_irq           <= n_irq;
			o_phy_enable    <= !suspend;
			o_data_en       <= n_data;
			o_rec_clk_en    <= n_rec;
			o_clk_fast_en   <= fast_on;
			o_txrx_clk_en   <= n_txrx;
			o_pll_en        <= !pll_off;
			o_edpd_active   <= ed_idle;
			o_link_pulse    <= link_pulse;
			o_pair_mon      <= pair_mask;
			o_energy_status <= energy_any;
			o_energy_chg    <= energy_chg;
			o_spd           <= spd;
			o_dev_reset     <= dev_reset;
			o_mgmt_grant    <= i_mgmt_req && mmd_ok;
			o_mgmt_refuse   <= i_mgmt_req && !mmd_ok;
		end
	end
endmodule

// file: tb/ppmc_monitor.sv
// Purpose: port checker of ppmc_top
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every ppmc_top instance
`timescale 1ns/1ps
module ppmc_chk (
	input wire logic       i_mclk,
	input wire logic       i_rst_b,
	input wire logic       i_mgmt_req,
	input wire logic       i_mgmt_mmd,
	input wire logic [4:0] i_mgmt_devad,
	input wire logic       i_pd_wr,
	input wire logic       i_spd_cg_override,
	input wire logic       i_isolate_bit,
	input wire logic [3:0] i_led_sel,
	input wire logic       i_idle_pll_off,
	input wire logic       i_edpd_en,
	input wire logic       o_port_indicator_output,
	input wire logic       o_link_up,
	input wire logic       o_clk_fast_en,
	input wire logic       o_txrx_clk_en,
	input wire logic       o_pll_en,
	input wire logic       o_edpd_active,
	input wire logic       o_spd,
	input wire logic       o_dev_reset,
	input wire logic       o_mgmt_grant,
	input wire logic       o_mgmt_refuse
);
	// ----------------------------------------
	// one clock domain
	// ----------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	// ----------------------------------------
	// management answers
	// ----------------------------------------
	mgmt_answer_a: assert property (i_mgmt_req |=> o_mgmt_grant != o_mgmt_refuse)
		else $error("request without exactly one answer");
	std_grant_a: assert property (i_mgmt_req && !i_mgmt_mmd |=> o_mgmt_grant)
		else $error("standard register access not granted");
	mmd_refuse_a: assert property (i_mgmt_req && i_mgmt_mmd && o_spd && !$past(i_pd_wr)
		&& (i_mgmt_devad == 5'h01 || !i_spd_cg_override) |=> o_mgmt_refuse)
		else $error("mmd access served in power-down");

	// ----------------------------------------
	// indicator and clocks
	// ----------------------------------------
	led_code_a: assert property (i_led_sel inside {4'hb, 4'hd, 4'he} |=> !o_port_indicator_output)
		else $error("indicator lit for off or reserved code");
	spd_gate_a: assert property (o_spd && $past(o_spd) && !$past(i_spd_cg_override) |-> !o_clk_fast_en)
		else $error("fast clocks run in power-down");
	isolate_stop_a: assert property ($past(i_isolate_bit) |-> !o_txrx_clk_en)
		else $error("txrx clocks run while isolated");

	// ----------------------------------------
	// energy power-down
	// ----------------------------------------
	edpd_off_a: assert property (!i_edpd_en |-> ##2 !o_edpd_active)
		else $error("energy power-down active while disabled");
	link_down_a: assert property (o_edpd_active && $past(o_edpd_active) |-> !o_link_up)
		else $error("link reported up in energy power-down");
	pll_idle_a: assert property (o_edpd_active && $past(o_edpd_active) && $past(i_idle_pll_off, 2) |-> !o_pll_en)
		else $error("pll kept on with idle pll-off set");
	reset_pulse_a: assert property (o_dev_reset |=> !o_dev_reset)
		else $error("device reset longer than one cycle");
endmodule

bind ppmc_top ppmc_chk u_chk (.*);

// file: tb/ppmc_host.sv
// Purpose: management host model issuing single requests
// Assumes: i_go sampled at the rising edge, request driven 1 ns later
// Notes:   idle qualifiers toggle so stale values never match
`timescale 1ns/1ps
module ppmc_host (
	input  wire logic       i_mclk,
	input  wire logic       i_go,
	input  wire logic       i_mmd,
	input  wire logic [4:0] i_devad,
	output logic            o_req,
	output logic            o_mmd,
	output logic [4:0]      o_devad
);
	logic       go_s;   // request seen at the edge
	logic       mmd_s;  // access kind seen at the edge
	logic [4:0] dev_s;  // device address seen at the edge

	// ----------------------------------------
	// request driver
	// ----------------------------------------
	initial begin
		o_req = 1'b0;
		o_mmd = 1'b0;
		o_devad = 5'h1e;
	end
	// one-cycle request, released qualifiers inverted each cycle
	always @(posedge i_mclk) begin
		go_s = i_go;
		mmd_s = i_mmd;
		dev_s = i_devad;
		#1;
		o_req = go_s;
		o_mmd = go_s ? mmd_s : ~o_mmd;
		o_devad = go_s ? dev_s : ~o_devad;
	end
endmodule

// file: tb/tb_phy_power_mode_control.sv
// Purpose: self-checking bench of ppmc_top
// Assumes: 40 MHz clock, tick shortened to 4 cycles
// Notes:   management answers checked from a queue
`timescale 1ns/1ps
module tb_phy_power_mode_control;
	localparam int TK = 4;
	logic i_mclk = 0, i_rst_b = 0, i_suspend_pin = 0, i_edpd_en = 0, i_edpd_rand_dis = 0;
	logic i_idle_pll_off = 0, i_force_1000 = 0, i_cable_diag = 0, i_energy_chg_clr = 0;
	logic i_pd_wr = 0, i_pd_wdata = 0, i_spd_pll_off = 0, i_spd_cg_override = 0, i_isolate_bit = 0;
	logic i_led_lo_state = 0, i_pdf = 0, i_phy_link_up = 0, i_phy_event = 0, i_phy_irq = 0;
	logic [1:0] i_edpd_mask_timer = 0, i_edpd_pulse_timer = 0, i_pair_sel = 0;
	logic [3:0] i_energy_det = 4'hf, i_led_sel = 0;
	logic [4:0] i_mode_strap = 0, i_mgmt_devad, h_dev = 0;
	logic i_mgmt_req, i_mgmt_mmd, h_go = 0, h_mmd = 0;
	logic o_port_indicator_output, o_link_up, o_event, o_irq, o_phy_enable, o_data_en;
	logic o_rec_clk_en, o_clk_fast_en, o_txrx_clk_en, o_pll_en, o_edpd_active, o_link_pulse;
	logic o_energy_status, o_energy_chg, o_spd, o_dev_reset, o_mgmt_grant, o_mgmt_refuse;
	logic [3:0] o_pair_mon;
	logic [31:0] rs = 32'h5a9b;  // xorshift state
	int error_cnt = 0;
	int n_tests = 0;
	int k;
	bit exp_q[$];                 // expected refuse flags

	// ----------------------------------------
	// clock, design and host
	// ----------------------------------------
	initial begin
		forever #12.5 i_mclk = ~i_mclk;
	end
	ppmc_top #(.TICK_CYC(TK)) DUT (.*);
	ppmc_host u_host (.i_mclk(i_mclk), .i_go(h_go), .i_mmd(h_mmd), .i_devad(h_dev),
		.o_req(i_mgmt_req), .o_mmd(i_mgmt_mmd), .o_devad(i_mgmt_devad));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// advance n edges, land 1 ns after the last one
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	// bounded wait for a flag, a timeout ends the run
	task automatic wait_hi(ref logic s, input int lim);
		int j;
		j = 0;
		while (s !== 1'b1 && j < lim) begin
			cyc(1);
			j++;
		end
		k = j;
		if (j == lim) begin
			error_cnt++;
			report_and_stop();
		end
	endtask
	// one management request, expectation queued
	task automatic mgmt(input logic mmd, input logic [4:0] dv, input bit refuse);
		exp_q.push_back(refuse);
		h_mmd = mmd;
		h_dev = dv;
		h_go = 1;
		cyc(1);
		h_go = 0;
		cyc(2);
	endtask
	// power-down bit write, o_spd settled on return
	task automatic pdw(input logic d);
		i_pd_wdata = d;
		i_pd_wr = 1;
		cyc(1);
		i_pd_wr = 0;
		cyc(1);
	endtask

	// ----------------------------------------
	// answer watcher
	// ----------------------------------------
	always @(posedge i_mclk) begin
		#2;
		if (o_mgmt_grant === 1'b1 || o_mgmt_refuse === 1'b1) begin
			if (exp_q.size() == 0) check("mgmt_extra", 1, 0);
			else check("mgmt_refuse", o_mgmt_refuse, exp_q.pop_front());
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		cyc(16);
		i_rst_b = 1;
		cyc(8);
		check("pll", o_pll_en, 1);
		check("edpd", o_edpd_active, 0);
		check("chg_idle", o_energy_chg, 0);
		// upper indicator codes with fault raised
		i_pdf = 1;
		for (int s = 11; s < 16; s++) begin
			i_led_sel = s[3:0];
			cyc(2);
			check("led", o_port_indicator_output, s == 12 || s == 15);
		end
		// lower codes follow the engine level
		for (int s = 0; s < 4; s++) begin
			rs = xs(rs);
			i_led_sel = rs[3:0] % 11;
			i_led_lo_state = rs[8];
			i_phy_event = rs[9];
			cyc(2);
			check("led_lo", o_port_indicator_output, rs[8]);
			check("event", o_event, rs[9]);
		end
		// suspend gating after the synchroniser
		i_phy_link_up = 1;
		i_phy_irq = 1;
		i_led_sel = 4'hf;
		i_phy_event = 0;
		cyc(2);
		i_suspend_pin = 1;
		cyc(3);
		check("early", o_phy_enable, 1);
		cyc(3);
		check("link", o_link_up, 0);
		check("irq_led", {o_irq, o_phy_enable, o_port_indicator_output}, 0);
		check("data_clk", {o_data_en, o_rec_clk_en, o_pll_en}, 1);
		mgmt(0, 5'h02, 0);
		i_suspend_pin = 0;
		cyc(7);
		check("resume", {o_link_up, o_irq, o_phy_enable, o_port_indicator_output}, 4'hf);
		// software power-down
		pdw(1);
		check("spd", {o_spd, o_clk_fast_en, o_txrx_clk_en, o_pll_en}, 4'h9);
		check("spd_led", o_port_indicator_output, 0);
		mgmt(0, 5'h03, 0);
		mgmt(1, 5'h01, 1);
		mgmt(1, 5'h03, 1);
		i_spd_cg_override = 1;
		cyc(2);
		check("ovr", {o_clk_fast_en, o_txrx_clk_en}, 2'h3);
		mgmt(1, 5'h03, 0);
		mgmt(1, 5'h01, 1);
		i_isolate_bit = 1;
		cyc(2);
		check("iso", o_txrx_clk_en, 0);
		i_isolate_bit = 0;
		i_spd_cg_override = 0;
		pdw(0);
		cyc(1);
		check("spd_exit", {o_spd, o_clk_fast_en}, 2'h1);
		// strap selects power-down at reset
		i_rst_b = 0;
		i_mode_strap = 5'b01001;
		cyc(16);
		i_rst_b = 1;
		cyc(10);
		check("strap", o_spd, 1);
		i_mode_strap = 0;
		i_spd_pll_off = 1;
		cyc(3);
		check("spd_pll", o_pll_en, 0);
		pdw(0);
		cyc(1);
		check("strap_exit", {o_spd, o_dev_reset}, 2'h1);
		i_spd_pll_off = 0;
		cyc(4);
		// energy loss while disabled
		i_energy_det = 0;
		cyc(40);
		check("edpd_dis", o_edpd_active, 0);
		check("chg", {o_energy_chg, o_energy_status}, 2'h2);
		i_energy_chg_clr = 1;
		cyc(1);
		i_energy_chg_clr = 0;
		cyc(2);
		check("chg_clr", o_energy_chg, 0);
		// mask time against the field
		rs = xs(rs);
		i_edpd_pulse_timer = rs[1:0];
		i_edpd_rand_dis = rs[2];
		for (int m = 0; m < 2; m++) begin
			i_edpd_en = 0;
			cyc(3);
			i_edpd_mask_timer = m[1:0];
			i_edpd_en = 1;
			wait_hi(o_edpd_active, 400);
			check("mask", k >= (8 << m) * TK && k <= ((8 << m) + 1) * TK + 8, 1);
		end
		check("idle", {o_link_up, o_rec_clk_en, o_pair_mon}, 6'h03);
		wait_hi(o_link_pulse, 700);
		check("pulse", o_link_pulse, 1);
		i_force_1000 = 1;
		cyc(2);
		check("pairs", o_pair_mon, 4'hf);
		i_cable_diag = 1;
		i_pair_sel = 2'h2;
		cyc(2);
		check("diag", o_pair_mon, 4'h4);
		i_force_1000 = 0;
		i_cable_diag = 0;
		i_idle_pll_off = 1;
		cyc(3);
		check("pll_off", o_pll_en, 0);
		i_idle_pll_off = 0;
		wait_hi(o_dev_reset, 6);
		check("dev_rst", o_dev_reset, 1);
		i_energy_det = 4'h3;
		cyc(8);
		check("wake", {o_edpd_active, o_energy_status}, 2'h1);
		report_and_stop();
	end
endmodule
